/* tcpcp_top.sv */
// channel 0 polarity, counter and prescaler with a classic wishbone slave
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tcpcp_consts.svh"

module tcpcp_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic filtered_edge_input_i,
    input wire logic ch0_ref_i,
    output logic ch0_output_signal_o,
    output logic ch0_compl_output_o,
    output logic ch0_capture_o,
    output logic ch0_trigger_o,
    output logic update_o
);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ****************
    // helpers
    // ****************
    function automatic logic tcpcp_hit(input logic [7:0] adr, input logic [7:0] off);
        return adr[7:2] == off[7:2];
    endfunction

    function automatic logic [31:0] tcpcp_merge(input logic [31:0] old,
                                                input logic [31:0] nw,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ****************
    // bus slave
    // ****************
    logic req;
    logic wr_go;
    logic ack_q;
    logic [31:0] dat_q;
    logic [31:0] rd_word;
    tcpcp_pkg::tcpcp_ctl_t ctl_q;
    tcpcp_pkg::tcpcp_ch0_cfg_t cfg_q;
    logic [1:0] protection_level_q;
    logic [15:0] cnt_q;
    logic [15:0] divider_value_q;
    logic [15:0] divider_shadow_q;
    logic [15:0] car_q;
    logic [15:0] div_q;
    logic locked;
    logic tick;
    logic upd;
    logic cnt_wr;

    assign req = cyc_i & stb_i;
    // writes land on the edge where the master sees ack
    assign wr_go = req & we_i & ack_q;
    assign ack_o = ack_q;
    assign dat_o = dat_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always_comb begin
        rd_word = `TCPCP_RST_WORD;
        if (tcpcp_hit(adr_i, `TCPCP_OFF_CTL)) begin
            rd_word[`TCPCP_CTL_CNT_EN_BIT] = ctl_q.count_en;
            rd_word[`TCPCP_CTL_IN_MODE_BIT] = ctl_q.input_mode;
        end
        if (tcpcp_hit(adr_i, `TCPCP_OFF_CHCTL)) begin
            rd_word[`TCPCP_CH_EN_BIT] = cfg_q.enable;
            rd_word[`TCPCP_CH_POL_BIT] = cfg_q.main_pol;
            rd_word[`TCPCP_CH_NPOL_BIT] = cfg_q.compl_pol;
        end
        if (tcpcp_hit(adr_i, `TCPCP_OFF_CNT)) begin
            rd_word[15:0] = cnt_q; // R7
        end
        if (tcpcp_hit(adr_i, `TCPCP_OFF_DIVIDER)) begin
            rd_word[15:0] = divider_value_q;
        end
        if (tcpcp_hit(adr_i, `TCPCP_OFF_CAR)) begin
            rd_word[15:0] = car_q;
        end
        if (tcpcp_hit(adr_i, `TCPCP_OFF_PROTECTION)) begin
            rd_word[1:0] = protection_level_q;
        end
    end

    // read data is captured as ack rises and holds through the ack cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= `TCPCP_RST_WORD;
        end else if (req & ~ack_q & ~we_i) begin
            dat_q <= rd_word;
        end
    end

    // ****************
    // control registers
    // ****************
    logic [31:0] wr_word;
    assign wr_word = tcpcp_merge(rd_word, dat_i, sel_i);
    assign locked = (protection_level_q == `TCPCP_LOCK_LEVEL_A)
                  | (protection_level_q == `TCPCP_LOCK_LEVEL_B);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q <= '0;
            protection_level_q <= 2'h0;
        end else if (wr_go) begin
            if (tcpcp_hit(adr_i, `TCPCP_OFF_CTL)) begin
                ctl_q.count_en <= wr_word[`TCPCP_CTL_CNT_EN_BIT];
                ctl_q.input_mode <= wr_word[`TCPCP_CTL_IN_MODE_BIT];
            end
            if (tcpcp_hit(adr_i, `TCPCP_OFF_PROTECTION)) begin
                protection_level_q <= wr_word[1:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= '0;
        end else if (wr_go & tcpcp_hit(adr_i, `TCPCP_OFF_CHCTL)) begin
            cfg_q.enable <= wr_word[`TCPCP_CH_EN_BIT];
            if (!locked) begin // R5
                cfg_q.main_pol <= wr_word[`TCPCP_CH_POL_BIT];
                cfg_q.compl_pol <= wr_word[`TCPCP_CH_NPOL_BIT];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            divider_value_q <= `TCPCP_RST_HALF;
            car_q <= `TCPCP_RST_HALF;
        end else if (wr_go) begin
            if (tcpcp_hit(adr_i, `TCPCP_OFF_DIVIDER)) begin
                divider_value_q <= wr_word[15:0];
            end
            if (tcpcp_hit(adr_i, `TCPCP_OFF_CAR)) begin
                car_q <= wr_word[15:0];
            end
        end
    end

    // ****************
    // prescaler and counter
    // ****************
    assign tick = ctl_q.count_en & (div_q == divider_shadow_q); // R9
    assign upd = tick & (cnt_q == car_q); // R12
    assign cnt_wr = wr_go & tcpcp_hit(adr_i, `TCPCP_OFF_CNT);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= `TCPCP_RST_HALF;
        end else if (!ctl_q.count_en || tick) begin
            div_q <= `TCPCP_RST_HALF; // R9
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    // a new divider waits in divider_value_q so a running period is never cut short
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            divider_shadow_q <= `TCPCP_RST_HALF;
        end else if (upd) begin
            divider_shadow_q <= divider_value_q; // R10
        end
    end

    // software load beats the count step in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= `TCPCP_RST_HALF;
        end else if (cnt_wr) begin
            cnt_q <= wr_word[15:0]; // R8
        end else if (upd) begin
            cnt_q <= `TCPCP_RST_HALF; // R12
        end else if (tick) begin
            cnt_q <= cnt_q + 16'h0001; // R12
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            update_o <= 1'b0;
        end else begin
            update_o <= upd & ~cnt_wr;
        end
    end

    // ****************
    // channel 0
    // ****************
    logic lvl_d;
    logic lvl_q;
    logic in_ok;
    logic out_act;
    // main bit inverts; a set complementary bit is a reserved input setting
    assign lvl_d = filtered_edge_input_i ^ cfg_q.main_pol; // R3 R4
    assign in_ok = ctl_q.input_mode & cfg_q.enable & ~cfg_q.compl_pol; // R4 R6
    assign out_act = ~ctl_q.input_mode & cfg_q.enable & ch0_ref_i; // R6

    // limitation: flipping the main bit can show up as one false edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lvl_q <= 1'b0;
            ch0_capture_o <= 1'b0;
            ch0_trigger_o <= 1'b0;
        end else begin
            lvl_q <= lvl_d;
            ch0_capture_o <= in_ok & lvl_d & ~lvl_q; // R4
            ch0_trigger_o <= in_ok & lvl_d; // R3
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ch0_output_signal_o <= 1'b0;
            ch0_compl_output_o <= 1'b0;
        end else begin
            ch0_output_signal_o <= out_act ^ cfg_q.main_pol; // R2
            ch0_compl_output_o <= out_act ^ cfg_q.compl_pol; // R1
        end
    end

    // ****************
    // assertions
    // ****************
    a_ack_single: assert property (ack_q |=> !ack_q)
        else $error("ack held longer than one cycle");

    a_cnt_read_val: assert property ( // R7
        (req & ~ack_q & ~we_i & tcpcp_hit(adr_i, `TCPCP_OFF_CNT))
        |=> (dat_o == {16'h0000, $past(cnt_q)}))
        else $error("counter read returned wrong word");

    a_cnt_write_load: assert property ( // R8
        (cnt_wr & (sel_i[1:0] == 2'h3)) |=> (cnt_q == $past(dat_i[15:0])))
        else $error("counter write not loaded");

    a_div_tick_point: assert property ( // R9
        (ctl_q.count_en && divider_shadow_q == 16'h0002 && div_q == 16'h0000 && !upd)
        ##1 (!upd && ctl_q.count_en) ##1 ctl_q.count_en |-> tick)
        else $error("prescaler tick not at divider plus one");

    a_shadow_only_update: assert property ( // R10
        !$stable(divider_shadow_q) |-> $past(upd))
        else $error("shadow changed without update event");

    a_cnt_wrap_zero: assert property ( // R12
        (upd && !cnt_wr) |=> (cnt_q == 16'h0000) && update_o)
        else $error("counter did not wrap with update");

    a_cnt_step_one: assert property ( // R12
        (tick && !upd && !cnt_wr) |=> (cnt_q == $past(cnt_q) + 16'h0001))
        else $error("counter did not step by one");

    a_pol_lock_hold: assert property ( // R5
        (wr_go && locked && tcpcp_hit(adr_i, `TCPCP_OFF_CHCTL))
        |=> $stable(cfg_q.main_pol) && $stable(cfg_q.compl_pol))
        else $error("polarity changed while protected");

    a_main_out_pol: assert property ( // R2
        (!ctl_q.input_mode && cfg_q.enable) |=>
        (ch0_output_signal_o == ($past(ch0_ref_i) ^ $past(cfg_q.main_pol))))
        else $error("main output polarity wrong");

    a_compl_out_pol: assert property ( // R1
        (!ctl_q.input_mode && cfg_q.enable) |=>
        (ch0_compl_output_o == ($past(ch0_ref_i) ^ $past(cfg_q.compl_pol))))
        else $error("complementary output polarity wrong");

    a_disabled_quiet: assert property ( // R6
        !cfg_q.enable |=> !ch0_capture_o && !ch0_trigger_o
        && (ch0_output_signal_o == $past(cfg_q.main_pol)))
        else $error("disabled channel still active");

    a_capture_edge_dir: assert property ( // R4
        ch0_capture_o |-> $past(in_ok) &&
        ($past(filtered_edge_input_i) == ~$past(cfg_q.main_pol)) &&
        ($past(filtered_edge_input_i, 2) == $past(cfg_q.main_pol, 2)))
        else $error("capture on wrong edge");

    c_update_seen: cover property (update_o);
    c_capture_seen: cover property (ch0_capture_o);
    c_locked_write: cover property (wr_go && locked && tcpcp_hit(adr_i, `TCPCP_OFF_CHCTL));
    c_shadow_change: cover property (upd && (divider_value_q != divider_shadow_q));

endmodule // tcpcp_top
`default_nettype wire

/* tcpcp_consts.svh */
// register offsets, field positions and reset values of the channel 0 timer block
// Operation
// R1 - In output mode the complementary output is active high when its polarity bit is 0 and active low when it is 1.
// R2 - In output mode the main output treats high as active when the main polarity bit is 0 and low when it is 1.
// R3 - In input mode both polarity bits together choose the active polarity of the channel 0 input.
// R4 - With both polarity bits 0 the rising input edge is used uninverted, with only the main bit set the falling edge is used inverted, and software leaves the complementary bit clear in input mode.
// R5 - Writes to either polarity bit are ignored while the protection level is 2'b11 or 2'b10.
// R6 - The channel function is off while the enable bit is 0 and on while it is 1.
// R7 - A read of the counter register returns the 16-bit count in the low bits and zero above.
// R8 - A write to the counter register loads the written value straight into the running counter.
// R9 - The counter clock is the kernel clock divided by the divider value plus one.
// R10 - A written divider value only takes effect when it is copied to the shadow at the next update event.
// R11 - Software programs a nonzero reload value above any expected count when capturing input.
// R12 - The counter steps by one per counter clock and on reaching the reload value returns to zero with an update event.
`ifndef TCPCP_CONSTS_SVH
`define TCPCP_CONSTS_SVH

// ****************
// offsets
// ****************
`define TCPCP_OFF_CTL 8'h00
`define TCPCP_OFF_CHCTL 8'h20
`define TCPCP_OFF_CNT 8'h24
`define TCPCP_OFF_DIVIDER 8'h28
`define TCPCP_OFF_CAR 8'h2C
`define TCPCP_OFF_PROTECTION 8'h44

// ****************
// field positions
// ****************
`define TCPCP_CH_EN_BIT 0
`define TCPCP_CH_POL_BIT 1
`define TCPCP_CH_NPOL_BIT 3
`define TCPCP_CTL_CNT_EN_BIT 0
`define TCPCP_CTL_IN_MODE_BIT 1

// ****************
// values
// ****************
`define TCPCP_RST_WORD 32'h0000_0000
`define TCPCP_RST_HALF 16'h0000
`define TCPCP_LOCK_LEVEL_A 2'h3
`define TCPCP_LOCK_LEVEL_B 2'h2

`endif

/* tcpcp_pkg.sv */
// types shared by the channel 0 timer block
package tcpcp_pkg;

    // ****************
    // channel 0 configuration
    // ****************
    typedef struct packed {
        logic compl_pol;
        logic main_pol;
        logic enable;
    } tcpcp_ch0_cfg_t;

    // ****************
    // timer control
    // ****************
    typedef struct packed {
        logic input_mode;
        logic count_en;
    } tcpcp_ctl_t;

endpackage : tcpcp_pkg

/* tcpcp_tb_top.sv */
// self-checking bench for the channel 0 timer block
`timescale 1ns/10ps
`default_nettype none
`include "tcpcp_consts.svh"

module tcpcp_tb_top;
    // ****************
    // signals
    // ****************
    logic clk_i, rst_i, cyc, stb, we, fin, ref_q;
    logic ack, out_m, out_c, cap, trig, upd;
    logic [7:0] adr;
    logic [3:0] sel, cur, wv;
    logic [31:0] dat, rdat, tmp, v, d;
    logic [31:0] seed = 32'h0000_afb4;
    int n_mismatch = 0;
    int comparisons = 0;
    int gap = 0, last_gap = 0, n_upd = 0, caps, p, c, p2;
    logic [7:0] regs [5] = '{`TCPCP_OFF_CNT, `TCPCP_OFF_DIVIDER, `TCPCP_OFF_CAR,
                             `TCPCP_OFF_CHCTL, 8'h80};
    // input rows: enable, compl pol, main pol, expected capture; compl stays clear in input mode
    logic [3:0] rows [5] = '{4'b1001, 4'b1011, 4'b0010, 4'b1001, 4'b0000};

    tcpcp_top tcpcp_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .filtered_edge_input_i(fin),
        .ch0_ref_i(ref_q), .ch0_output_signal_o(out_m), .ch0_compl_output_o(out_c),
        .ch0_capture_o(cap), .ch0_trigger_o(trig), .update_o(upd)
    );

    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic exp_lvl(logic en, logic r, logic pol);
        return (en & r) ^ pol;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_count(input int got, input int exp, input string what);
        comparisons++;
        if (got != exp) begin
            n_mismatch++;
            $display("Error %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    // classic cycle: held until ack is sampled, read data taken at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dd, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= dd;
        sel <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            $display("Error %0t: no ack from the register bus", $time);
        end
        tmp = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // spacing of update pulses, in kernel clocks
    always @(posedge clk_i) begin
        if (upd === 1'b1) begin
            last_gap <= gap;
            gap <= 1;
            n_upd <= n_upd + 1;
        end else begin
            gap <= gap + 1;
        end
    end

    task automatic wait_upd();
        int k, n0;
        n0 = n_upd;
        k = 0;
        while (n_upd == n0 && k < 2000) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 2000) begin
            n_mismatch++;
            $display("Error %0t: no update pulse", $time);
        end
    endtask

    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ****************
    // clock, watchdog
    // ****************
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // whole run needs a few hundred cycles, so this only cuts a hang
    initial begin
        #(40 * 20000);
        n_mismatch++;
        $display("Error %0t: watchdog expired", $time);
        test_done();
    end

    // ****************
    // scenarios
    // ****************
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, fin, ref_q} = 5'h00;
        adr = 8'h00;
        sel = 4'h0;
        dat = 32'h0000_0000;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, regs[i], 32'h0, 4'hf);
            chk(tmp, 32'h0, "reset or unmapped read");
        end
        v = rnd();
        wb(1'b1, `TCPCP_OFF_CNT, v, 4'hf);
        wb(1'b0, `TCPCP_OFF_CNT, 32'h0, 4'hf);
        chk(tmp, {16'h0000, v[15:0]}, "count load");
        d = rnd();
        wb(1'b1, `TCPCP_OFF_CNT, d, 4'h1);
        wb(1'b0, `TCPCP_OFF_CNT, 32'h0, 4'hf);
        chk(tmp, {16'h0000, v[15:8], d[7:0]}, "count byte lane");
        // division: the new divider must wait for the next wrap
        p = int'(rnd() % 5) + 1;
        c = int'(rnd() % 8) + 3;
        p2 = p + 1 + int'(rnd() % 3);
        wb(1'b1, `TCPCP_OFF_DIVIDER, 32'(p), 4'hf);
        wb(1'b1, `TCPCP_OFF_CAR, 32'(c), 4'hf);
        wb(1'b1, `TCPCP_OFF_CNT, 32'h0, 4'hf);
        wb(1'b1, `TCPCP_OFF_CTL, 32'h1, 4'hf);
        wait_upd();
        wb(1'b1, `TCPCP_OFF_DIVIDER, 32'(p2), 4'hf);
        wait_upd();
        chk_count(last_gap, (p + 1) * (c + 1), "old division");
        wait_upd();
        chk_count(last_gap, (p2 + 1) * (c + 1), "new division");
        wb(1'b0, `TCPCP_OFF_DIVIDER, 32'h0, 4'hf);
        chk(tmp, 32'(p2), "divider readback");
        wb(1'b1, `TCPCP_OFF_CTL, 32'h0, 4'hf);
        // output mode: every enable, polarity and reference level
        for (int i = 0; i < 16; i++) begin
            ref_q <= i[3];
            wb(1'b1, `TCPCP_OFF_CHCTL, {28'h0, i[2], 1'b0, i[1], i[0]}, 4'hf);
            repeat (3) @(posedge clk_i);
            chk_pin(out_m, exp_lvl(i[0], i[3], i[1]), "main output");
            chk_pin(out_c, exp_lvl(i[0], i[3], i[2]), "compl output");
        end
        // every protection level, polarity bits flipped each time
        cur = 4'hb;
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, `TCPCP_OFF_PROTECTION, 32'(k), 4'hf);
            wv = {~cur[3], 1'b0, ~cur[1], ~cur[0]};
            wb(1'b1, `TCPCP_OFF_CHCTL, {28'h0, wv}, 4'hf);
            if (k >= 2) cur = {cur[3], 1'b0, cur[1], wv[0]};
            else cur = wv;
            wb(1'b0, `TCPCP_OFF_CHCTL, 32'h0, 4'hf);
            chk(tmp, {28'h0, cur}, "protected write");
        end
        wb(1'b1, `TCPCP_OFF_PROTECTION, 32'h0, 4'hf);
        // input mode: start inactive, then one active edge
        wb(1'b1, `TCPCP_OFF_CHCTL, 32'h0, 4'hf);
        wb(1'b1, `TCPCP_OFF_CTL, 32'h2, 4'hf);
        for (int j = 0; j < 5; j++) begin
            fin <= rows[j][1];
            wb(1'b1, `TCPCP_OFF_CHCTL, {28'h0, rows[j][2], 1'b0, rows[j][1], rows[j][3]}, 4'hf);
            repeat (4) @(posedge clk_i);
            fin <= ~rows[j][1];
            caps = 0;
            repeat (4) begin
                @(posedge clk_i);
                if (cap === 1'b1) caps++;
            end
            chk_count(caps, int'(rows[j][0]), "capture count");
            if (rows[j][3]) chk_pin(trig, rows[j][0], "trigger level");
        end
        test_done();
    end
endmodule // tcpcp_tb_top
`default_nettype wire
